//--- dv/jl_dv_pkg.sv
// bench helpers: mode table and both checksum methods
// assumes the eleven-byte layout of the link configuration bank
package jl_dv_pkg;
	// ====
	// mode table, converter count 0 marks a missing mode
	localparam int TM[11] = '{4, 4, 4, 4, 2, 2, 2, 2, 0, 1, 1};
	localparam int TL[11] = '{8, 8, 4, 2, 4, 4, 2, 1, 1, 2, 1};
	localparam int TS[11] = '{1, 2, 1, 1, 1, 2, 1, 1, 1, 1, 1};
	localparam int TF[11] = '{1, 2, 2, 4, 1, 2, 2, 4, 1, 1, 2};
	typedef logic [7:0] jl_cfg_t [11];
	// field sum or byte sum, low eight bits
	function automatic logic [7:0] jl_sum(jl_cfg_t c, logic meth);
		logic [7:0] s;
		s = 8'h00;
		if (meth) begin
			for (int i = 0; i < 11; i++) s += c[i];
			return s;
		end
		s = c[0] + c[1][3:0] + c[1][7:4] + c[2][4:0] + c[2][5] + c[2][6] + c[3][7]
			+ c[3][4:0] + c[4] + c[5][4:0] + c[6] + c[7][7:6] + c[7][4:0] + c[8][7:5]
			+ c[8][4:0] + c[9][7:5] + c[9][4:0] + c[10][7] + c[10][4:0];
		return s;
	endfunction
endpackage

//--- dv/jl_tx_model.sv
// far-end transmitter model: sends its lane-zero configuration sum
// assumes requests are raised just after a rising edge
`timescale 1ns/1ps
module jl_tx_model
	import jl_dv_pkg::*;
(
	input wire logic mclk_i, // system clock
	input wire logic send_i, // request one checksum
	input wire logic link_i, // link to carry it
	input wire logic meth_i, // checksum method in use
	input wire logic bad_i, // corrupt the sum on purpose
	input wire logic [7:0] cfg_i [11], // transmitter settings
	output logic [7:0] sum_o, // checksum lane value
	output logic vld_o, // one-cycle qualifier
	output logic link_o // link number
);
	logic [7:0] last = 8'h00; // last value sent
	initial begin
		sum_o = 8'hff;
		vld_o = 1'b0;
		link_o = 1'b0;
	end
	// ====
	// drive just after the edge, scramble the lane when idle
	always @(posedge mclk_i) begin : drv
		logic go;
		go = send_i;
		#1;
		if (go) begin
			last = jl_sum(cfg_i, meth_i) ^ {7'h00, bad_i};
			sum_o = last;
			vld_o = 1'b1;
			link_o = link_i;
		end else begin
			sum_o = ~last;
			vld_o = 1'b0;
			link_o = ~link_o;
		end
	end
endmodule

//--- dv/serial_link_param_setup_tb.sv
// self-checking bench for the link parameter setup block
// assumes one clock domain and byte register strobes
`timescale 1ns/1ps
module serial_link_param_setup_tb
	import jl_pkg::*, jl_dv_pkg::*;
;
	localparam logic [7:0] UP[5] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h02}; // last is illegal
	localparam logic [15:0] CN[4] = '{16'd143, 16'd144, 16'd1240, 16'd1241}; // rate edges
	logic mclk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, snd = 1'b0, bad = 1'b0;
	logic meth = 1'b0, dl = 1'b0, tl = 1'b0, pv, pl, rvld, two, esync, cerr, mis, e;
	logic [11:0] addr = 12'h000;
	logic [7:0] wd = 8'h00, ps, rdat, lane_en, lpo, v, le, ups;
	logic [1:0] len, lrst, dscr, lr;
	logic [15:0] dac;
	logic [31:0] r, q;
	jl_cfg_t c0 = '{default: 8'h00}, c1, cs = '{default: 8'h00};
	integer seed = 32'h57a4c85f;
	int mismatches = 0, check_count = 0, md, fl;
	always #5 mclk_i = ~mclk_i;
	jl_link_setup #(.LINKS(2)) i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
		.rx_cfg_sum_i(ps), .rx_cfg_sum_vld_i(pv), .rx_cfg_link_i(pl),
		.reg_rdata_o(rdat), .reg_rvalid_o(rvld), .link_enable_o(len), .link_reset_o(lrst),
		.two_link_o(two), .descramble_en_o(dscr), .lane_enable_o(lane_en),
		.lane_power_off_o(lpo), .ext_sync_ref_o(esync), .cfg_error_o(cerr),
		.sum_mismatch_o(mis));
	jl_tx_model i_tx (.mclk_i(mclk_i), .send_i(snd), .link_i(tl), .meth_i(meth),
		.bad_i(bad), .cfg_i(cs), .sum_o(ps), .vld_o(pv), .link_o(pl));
	// ====
	// bus tasks and comparison
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic wreg(logic [11:0] a, logic [7:0] d);
		addr = a;
		wd = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(1);
	endtask
	task automatic rchk(logic [11:0] a, logic [7:0] exp);
		addr = a;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		chk({7'h00, rvld}, 8'h01);
		chk(rdat, exp);
		cyc(1);
	endtask
	function automatic logic [7:0] ctl(bit s);
		return {1'b0, meth, 2'b00, dl, s, dl, 1'b1};
	endfunction
	task automatic wbank(bit s, jl_cfg_t c);
		wreg(ADDR_LINK_CTRL, ctl(s));
		for (int i = 0; i < 11; i++) wreg(ADDR_CFG_FIRST + 12'(i), c[i]);
	endtask
	// ====
	// expected legality of a setup
	function automatic bit jl_experr(int m, jl_cfg_t a, jl_cfg_t b, logic [15:0] d,
		logic [7:0] u, bit two_l);
		int st;
		longint rt;
		bit x;
		st = (u == 8'h00) ? 0 : (u == 8'h01) ? 1 : (u == 8'h03) ? 2 : (u == 8'h04) ? 3 : -1;
		if (TM[m] == 0 || st < 0) return 1'b1;
		rt = (longint'(d) >> st) * 20 * TM[m] / TL[m];
		x = rt < 1440 || rt > 12400;
		x |= a[3][4:0] != 5'(TL[m] - 1) || a[4] != 8'(TF[m] - 1) || a[6] != 8'(TM[m] - 1);
		x |= a[9][4:0] != 5'(TS[m] - 1) || a[7][4:0] != 5'd15 || a[8][4:0] != 5'd15;
		x |= a[10][7] != (TF[m] == 1);
		x |= a[5][4:0] != 5'd31 && (a[5][4:0] != 5'd15 || m == 0 || m == 4 || m == 9);
		for (int i = 0; i < 11; i++) x |= two_l && i != 2 && a[i] != b[i];
		return x | (two_l && m < 4);
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#300000;
		mismatches++;
		tally_and_finish();
	end
	// ====
	// main sequence
	initial begin
		repeat (12) @(posedge mclk_i);
		#1;
		chk(lpo, RST_BYTE);
		rst_n_i = 1'b1;
		cyc(1);
		chk({7'h00, cerr}, 8'h01);
		rchk(ADDR_LANE_PWR_OFF, RST_BYTE);
		wreg(12'h7ff, 8'hff);
		rchk(12'h7ff, 8'h00);
		for (int n = 0; n < 40; n++) begin
			r = $random(seed);
			q = $random(seed);
			md = (n < 4) ? 0 : (n == 4) ? 4 : int'(r[7:0] % 11);
			fl = (n < 4) ? 0 : int'(r[10:8]);
			dl = (n >= 4) && r[12];
			meth = r[13];
			ups = (n < 4) ? 8'h00 : UP[r[16:14] % 5];
			dac = (n < 4) ? CN[n] : 16'(100 + r[31:20] % 1500);
			c0[0] = q[7:0];
			c0[1] = q[15:8];
			c0[2] = {1'b0, q[22:16]};
			c0[3] = {q[23], 2'b00, 5'(TL[md] - 1)};
			c0[4] = 8'(TF[md] - 1);
			c0[5] = ((n == 4) || ((n > 4) && r[11])) ? 8'h0f : 8'h1f;
			c0[6] = 8'(TM[md] - 1);
			c0[7] = {q[25:24], 6'h0f};
			c0[8] = {2'b00, q[26], 5'h0f};
			c0[9] = {3'h1, 5'(TS[md] - 1)};
			c0[10] = {TF[md] == 1, 7'h00};
			if (fl == 1) c0[10][7] = ~c0[10][7];
			if (fl == 2) c0[7][4:0] = 5'h0d;
			if (fl == 3) c0[8][4:0] = 5'h07;
			c1 = c0;
			c1[2] = {1'b0, q[30:24]};
			if (fl == 4) c1[4] = c0[4] ^ 8'h01;
			if (!dl) c1[3][7] = q[31];
			wbank(1'b1, c1);
			wbank(1'b0, c0);
			wreg(ADDR_MODE, 8'(md));
			wreg(ADDR_UPSAMPLE, ups);
			wreg(ADDR_DAC_RATE_LO, dac[7:0]);
			wreg(ADDR_DAC_RATE_HI, dac[15:8]);
			v = (n == 0) ? 8'hcc : q[7:0] ^ r[7:0];
			wreg(ADDR_LANE_PWR_OFF, v);
			chk(lpo, v);
			rchk(ADDR_LANE_PWR_OFF, v);
			e = jl_experr(md, c0, c1, dac, ups, dl);
			chk({7'h00, cerr}, {7'h00, e});
			chk({7'h00, two}, {7'h00, dl});
			chk({6'h00, len}, {6'h00, dl, 1'b1});
			chk({6'h00, dscr}, {6'h00, c1[3][7], c0[3][7]});
			chk({7'h00, esync}, {7'h00, q[26]});
			le = 8'((1 << TL[md]) - 1);
			if (dl) le = le | (le << 4);
			if (!e) chk(lane_en, le);
			rchk(ADDR_CFG_SUM, jl_sum(c0, meth));
			rchk(ADDR_CFG_FIRST + 12'h002, c0[2]);
			wreg(ADDR_LINK_CTRL, ctl(1'b1));
			cyc(2);
			rchk(ADDR_CFG_SUM, jl_sum(c1, meth));
			rchk(ADDR_CFG_FIRST + 12'h002, c1[2]);
			wreg(ADDR_LINK_RST, {6'h00, q[29:28]});
			lr = dl ? q[29:28] : {2{q[28]}};
			chk({6'h00, lrst}, {6'h00, lr});
			tl = q[30];
			cs = c0;
			if (tl) cs = c1;
			bad = q[27];
			snd = 1'b1;
			cyc(1);
			snd = 1'b0;
			cyc(2);
			chk({7'h00, mis}, {7'h00, q[27]});
			wreg(ADDR_STATUS, 8'h02);
			chk({7'h00, mis}, 8'h00);
			$display("test %0d done", n);
		end
		tally_and_finish();
	end
endmodule

//--- rtl/jl_cfg_sum.sv
// configuration checksum of one link: field sum or register byte sum
// assumes minus-one fields are stored as they travel on the link
`timescale 1ns/1ps
module jl_cfg_sum
	import jl_pkg::*;
(
	input wire logic [7:0] cfg_i [CFG_BYTES], // link configuration bytes
	input wire logic method_i, // 0 field sum, 1 register sum
	output logic [7:0] sum_o // modulo-256 checksum
);
	// ==========================================================
	// both sums, then pick
	always_comb begin
		logic [7:0] reg_sum;
		logic [7:0] fld_sum;
		reg_sum = 8'h00;
		fld_sum = 8'h00;
		// plain byte sum over the whole block
		for (int b = 0; b < CFG_BYTES; b++) begin
			reg_sum = reg_sum + cfg_i[b];
		end
		// field sum, counts held minus one already
		fld_sum = cfg_i[IDX_DID] + 8'(cfg_i[IDX_BID][3:0]) + 8'(cfg_i[IDX_BID][7:4]);
		fld_sum = fld_sum + 8'(cfg_i[IDX_LID][4:0]) + 8'(cfg_i[IDX_LID][PHADJ_BIT]);
		fld_sum = fld_sum + 8'(cfg_i[IDX_LID][ADJDIR_BIT]) + 8'(cfg_i[IDX_L][4:0]);
		fld_sum = fld_sum + 8'(cfg_i[IDX_L][SCR_BIT]) + cfg_i[IDX_F];
		fld_sum = fld_sum + 8'(cfg_i[IDX_K][4:0]) + cfg_i[IDX_M];
		fld_sum = fld_sum + 8'(cfg_i[IDX_N][4:0]) + 8'(cfg_i[IDX_N][7:6]);
		fld_sum = fld_sum + 8'(cfg_i[IDX_NP][4:0]) + 8'(cfg_i[IDX_NP][7:5]);
		fld_sum = fld_sum + 8'(cfg_i[IDX_S][4:0]) + 8'(cfg_i[IDX_S][7:5]);
		fld_sum = fld_sum + 8'(cfg_i[IDX_HD][4:0]) + 8'(cfg_i[IDX_HD][HD_BIT]);
		sum_o = method_i ? reg_sum : fld_sum; // R15 R16 R17
	end
endmodule

//--- rtl/jl_link_setup.sv
// link parameter setup and checking for an eight-lane serial receiver
// assumes byte register access decoded from the serial control port
// Overview of operation
// [R1] modes 0-3: four converters, single link
// [R2] modes 4-7, 9, 10: single or dual link
// [R3] lane rate from sample rate, checked window
// [R4] sample rate is clock over upsample factor
// [R5] high density set exactly when one octet
// [R6] resolution and sample width both sixteen
// [R7] thirty-two frames in modes 0, 4, 9
// [R8] dual link gives separately resettable links
// [R9] dual links identical, dual-capable modes only
// [R10] transmitter settings match receiver settings
// [R11] scrambling setting enables descrambling
// [R12] link select steers configuration accesses
// [R13] thermometer lane mask enables used lanes
// [R14] mask bit one powers lane off
// [R15] checksum method must match transmitter
// [R16] field method sums fields, minus-one counts
// [R17] register method sums eleven bytes
// [R18] first-lane checksum held for comparison
// [R19] subclass selects external sync reference use
// [R20] subclass zero aligns on internal clock
// [R21] flag checksum mismatch for software
`timescale 1ns/1ps
module jl_link_setup
	import jl_pkg::*;
#(
	parameter int LINKS = 2 // link banks
) (
	input wire logic mclk_i, // system clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire logic [11:0] reg_addr_i, // register address
	input wire logic [7:0] reg_wdata_i, // write data
	input wire logic reg_wr_i, // write strobe
	input wire logic reg_rd_i, // read strobe
	input wire logic [7:0] rx_cfg_sum_i, // checksum seen on lane zero
	input wire logic rx_cfg_sum_vld_i, // pulse with rx_cfg_sum_i
	input wire logic rx_cfg_link_i, // link that carried it
	output logic [7:0] reg_rdata_o, // read data
	output logic reg_rvalid_o, // read data valid pulse
	output logic [1:0] link_enable_o, // per link enable
	output logic [1:0] link_reset_o, // per link reset
	output logic two_link_o, // dual link running
	output logic [1:0] descramble_en_o, // per link descrambler on
	output logic [7:0] lane_enable_o, // logical lanes enabled
	output logic [7:0] lane_power_off_o, // physical lanes off
	output logic ext_sync_ref_o, // external reference in use
	output logic cfg_error_o, // configuration not legal
	output logic sum_mismatch_o // sticky checksum mismatch
);
	// elaboration check: the logic serves exactly two link banks
	if (LINKS != 2) begin : g_links_chk
		$error("jl_link_setup: LINKS must be 2");
	end


	// ==========================================================
	// register state
	logic [7:0] cfg_r [LINKS][CFG_BYTES]; // link configuration banks
	logic [7:0] cfg_nxt [LINKS][CFG_BYTES];
	logic [7:0] lane_power_off_mask_r; // powered-off lanes
	logic [7:0] lane_power_off_mask_nxt;
	logic [7:0] link_ctrl_r; // method, dual, select, enables
	logic [7:0] link_ctrl_nxt;
	logic [15:0] dac_rate_r; // converter clock in MHz
	logic [15:0] dac_rate_nxt;
	logic [7:0] mode_r; // operating mode number
	logic [7:0] mode_nxt;
	logic [7:0] upsample_mode_code_r; // upsample factor code
	logic [7:0] upsample_mode_code_nxt;
	logic [1:0] link_rst_r; // software link resets
	logic [1:0] link_rst_nxt;

	// decoded controls
	logic checksum_method_sel; // 0 fields, 1 registers
	logic two_link_enable; // dual link
	logic link_select; // bank for configuration access
	logic cfg_hit; // address in configuration block
	logic [3:0] cfg_idx; // byte index in block
	logic [7:0] sum_c [LINKS]; // computed checksums

	assign checksum_method_sel = link_ctrl_r[CTRL_SUM_METHOD_BIT];
	assign two_link_enable = link_ctrl_r[CTRL_TWO_LINK_BIT];
	assign link_select = link_ctrl_r[CTRL_LINK_SEL_BIT];
	assign cfg_hit = (reg_addr_i >= ADDR_CFG_FIRST) && (reg_addr_i <= ADDR_CFG_LAST);
	assign cfg_idx = 4'(reg_addr_i - ADDR_CFG_FIRST);

	// ==========================================================
	// register writes
	always_comb begin
		cfg_nxt = cfg_r;
		lane_power_off_mask_nxt = lane_power_off_mask_r;
		link_ctrl_nxt = link_ctrl_r;
		dac_rate_nxt = dac_rate_r;
		mode_nxt = mode_r;
		upsample_mode_code_nxt = upsample_mode_code_r;
		link_rst_nxt = link_rst_r;
		if (reg_wr_i) begin
			// address decode
			if (reg_addr_i == ADDR_LANE_PWR_OFF) begin
				lane_power_off_mask_nxt = reg_wdata_i; // R14
			end else if (reg_addr_i == ADDR_LINK_CTRL) begin
				link_ctrl_nxt = reg_wdata_i;
			end else if (cfg_hit) begin
				cfg_nxt[link_select][cfg_idx] = reg_wdata_i; // R12
			end else if (reg_addr_i == ADDR_DAC_RATE_LO) begin
				dac_rate_nxt[7:0] = reg_wdata_i;
			end else if (reg_addr_i == ADDR_DAC_RATE_HI) begin
				dac_rate_nxt[15:8] = reg_wdata_i;
			end else if (reg_addr_i == ADDR_MODE) begin
				mode_nxt = reg_wdata_i;
			end else if (reg_addr_i == ADDR_UPSAMPLE) begin
				upsample_mode_code_nxt = reg_wdata_i;
			end else if (reg_addr_i == ADDR_LINK_RST) begin
				link_rst_nxt = reg_wdata_i[1:0];
			end
		end
	end

	// register file flops
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			for (int k = 0; k < LINKS; k++) begin
				for (int b = 0; b < CFG_BYTES; b++) begin
					cfg_r[k][b] <= RST_BYTE;
				end
			end
			lane_power_off_mask_r <= RST_BYTE;
			link_ctrl_r <= RST_BYTE;
			dac_rate_r <= RST_DAC_RATE;
			mode_r <= RST_BYTE;
			upsample_mode_code_r <= RST_BYTE;
			link_rst_r <= 2'b00;
		end else begin
			cfg_r <= cfg_nxt;
			lane_power_off_mask_r <= lane_power_off_mask_nxt;
			link_ctrl_r <= link_ctrl_nxt;
			dac_rate_r <= dac_rate_nxt;
			mode_r <= mode_nxt;
			upsample_mode_code_r <= upsample_mode_code_nxt;
			link_rst_r <= link_rst_nxt;
		end
	end

	// ==========================================================
	// checksum per link bank
	for (genvar g = 0; g < LINKS; g++) begin : g_sum
		jl_cfg_sum u_sum (
			.cfg_i(cfg_r[g]),
			.method_i(checksum_method_sel),
			.sum_o(sum_c[g])
		);
	end

	// ==========================================================
	// legality check of the programmed setup
	jl_mode_s mi; // table entry of mode_r
	logic [2:0] ups_shift; // doubling stages
	logic ups_ok; // known upsample code
	logic [31:0] lane_rate_mhz; // per-lane bit rate
	logic cfg_err_c; // any check failed

	always_comb begin
		logic [15:0] data_rate;
		data_rate = 16'h0000;
		mi = jl_mode_info(mode_r);
		ups_ok = 1'b1;
		ups_shift = 3'd0;
		// sample rate from converter clock
		case (upsample_mode_code_r)
			UPS_1X: ups_shift = 3'd0; // R4
			UPS_2X: ups_shift = 3'd1;
			UPS_4X: ups_shift = 3'd2;
			UPS_8X: ups_shift = 3'd3;
			default: ups_ok = 1'b0;
		endcase
		data_rate = dac_rate_r >> ups_shift; // R4
		lane_rate_mhz = (32'(data_rate) * LANE_RATE_MULT * 32'(mi.m)) / 32'(mi.l); // R3
		cfg_err_c = !mi.valid || !ups_ok;
		cfg_err_c = cfg_err_c || (lane_rate_mhz < LANE_RATE_MIN_MHZ); // R3
		cfg_err_c = cfg_err_c || (lane_rate_mhz > LANE_RATE_MAX_MHZ);
		// dual link only on dual-capable modes
		cfg_err_c = cfg_err_c || (two_link_enable && !mi.dual_ok); // R9
		for (int k = 0; k < LINKS; k++) begin
			// counts must match the mode
			if (cfg_r[k][IDX_L][4:0] != 5'(mi.l - 4'h1) ||
				cfg_r[k][IDX_F] != 8'(mi.f - 4'h1) ||
				cfg_r[k][IDX_M] != 8'(mi.m - 4'h1) ||
				cfg_r[k][IDX_S][4:0] != 5'(mi.s - 4'h1)) begin
				cfg_err_c = cfg_err_c || (k == 0) || two_link_enable; // R1 R2
			end
			// high density exactly when one octet per lane
			if (cfg_r[k][IDX_HD][HD_BIT] != (cfg_r[k][IDX_F] == 8'h00)) begin
				cfg_err_c = cfg_err_c || (k == 0) || two_link_enable; // R5
			end
			// sixteen-bit resolution and sample width
			if (cfg_r[k][IDX_N][4:0] != RES_M1 || cfg_r[k][IDX_NP][4:0] != RES_M1) begin
				cfg_err_c = cfg_err_c || (k == 0) || two_link_enable; // R6
			end
			// frames per multiframe
			if (cfg_r[k][IDX_K][4:0] != K_LONG_M1 &&
				(mi.k32_only || cfg_r[k][IDX_K][4:0] != K_SHORT_M1)) begin
				cfg_err_c = cfg_err_c || (k == 0) || two_link_enable; // R7
			end
		end
		// dual links carry identical parameters, lane id aside
		for (int b = 0; b < CFG_BYTES; b++) begin
			if (b != IDX_LID && cfg_r[0][b] != cfg_r[1][b]) begin
				cfg_err_c = cfg_err_c || two_link_enable; // R9
			end
		end
	end

	// ==========================================================
	// status, outputs and read port
	logic [7:0] held_sum_r [LINKS]; // first-lane checksum kept
	logic [7:0] held_sum_nxt [LINKS];
	logic [7:0] rdata_nxt;
	logic mismatch_nxt;
	logic clr_mismatch; // write one to clear

	// thermometer mask for a minus-one lane count
	function automatic logic [7:0] therm(input logic [4:0] lm1);
		return (lm1 > 5'd7) ? 8'hff : 8'((16'h0002 << lm1) - 16'h0001);
	endfunction

	logic [7:0] lane_mask0_c; // thermometer of bank 0
	logic [7:0] lane_mask1_c; // thermometer of bank 1
	assign lane_mask0_c = therm(cfg_nxt[0][IDX_L][4:0]); // R13
	assign lane_mask1_c = therm(cfg_nxt[1][IDX_L][4:0]); // R13

	assign clr_mismatch = reg_wr_i && (reg_addr_i == ADDR_STATUS) &&
		reg_wdata_i[ST_MISMATCH_BIT];

	always_comb begin
		held_sum_nxt = held_sum_r;
		mismatch_nxt = sum_mismatch_o && !clr_mismatch;
		// keep the expected sum, compare with the received one
		for (int k = 0; k < LINKS; k++) begin
			held_sum_nxt[k] = sum_c[k]; // R18
		end
		if (rx_cfg_sum_vld_i && rx_cfg_sum_i != held_sum_r[rx_cfg_link_i]) begin
			mismatch_nxt = 1'b1; // R21
		end
		// read decode, unmapped reads zero
		rdata_nxt = 8'h00;
		if (reg_addr_i == ADDR_LANE_PWR_OFF) begin
			rdata_nxt = lane_power_off_mask_r;
		end else if (reg_addr_i == ADDR_LINK_CTRL) begin
			rdata_nxt = link_ctrl_r;
		end else if (cfg_hit) begin
			rdata_nxt = cfg_r[link_select][cfg_idx]; // R12
		end else if (reg_addr_i == ADDR_CFG_SUM) begin
			rdata_nxt = held_sum_r[link_select]; // R18
		end else if (reg_addr_i == ADDR_DAC_RATE_LO) begin
			rdata_nxt = dac_rate_r[7:0];
		end else if (reg_addr_i == ADDR_DAC_RATE_HI) begin
			rdata_nxt = dac_rate_r[15:8];
		end else if (reg_addr_i == ADDR_MODE) begin
			rdata_nxt = mode_r;
		end else if (reg_addr_i == ADDR_UPSAMPLE) begin
			rdata_nxt = upsample_mode_code_r;
		end else if (reg_addr_i == ADDR_STATUS) begin
			rdata_nxt = {6'h00, sum_mismatch_o, cfg_error_o};
		end else if (reg_addr_i == ADDR_LINK_RST) begin
			rdata_nxt = {6'h00, link_rst_r};
		end
	end

	// output flops
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			held_sum_r[0] <= RST_BYTE;
			held_sum_r[1] <= RST_BYTE;
			reg_rdata_o <= RST_BYTE;
			reg_rvalid_o <= 1'b0;
			link_enable_o <= 2'b00;
			link_reset_o <= 2'b00;
			two_link_o <= 1'b0;
			descramble_en_o <= 2'b00;
			lane_enable_o <= RST_BYTE;
			lane_power_off_o <= RST_BYTE;
			ext_sync_ref_o <= 1'b0;
			cfg_error_o <= 1'b0;
			sum_mismatch_o <= 1'b0;
		end else begin
			held_sum_r <= held_sum_nxt;
			reg_rdata_o <= reg_rd_i ? rdata_nxt : reg_rdata_o;
			reg_rvalid_o <= reg_rd_i;
			link_enable_o <= link_ctrl_nxt[1:0];
			// single link: second link follows the first
			link_reset_o <= link_rst_map(link_ctrl_nxt, link_rst_nxt); // R8
			two_link_o <= link_ctrl_nxt[CTRL_TWO_LINK_BIT]; // R8
			descramble_en_o <= {cfg_nxt[1][IDX_L][SCR_BIT], cfg_nxt[0][IDX_L][SCR_BIT]}; // R11
			lane_enable_o <= link_ctrl_nxt[CTRL_TWO_LINK_BIT] ?
				{lane_mask1_c[3:0], lane_mask0_c[3:0]} :
				lane_mask0_c; // R13
			lane_power_off_o <= lane_power_off_mask_nxt; // R14
			// one: external reference, zero: internal alignment clock
			ext_sync_ref_o <= (cfg_nxt[0][IDX_NP][7:5] == 3'd1); // R19 R20
			cfg_error_o <= cfg_err_c;
			sum_mismatch_o <= mismatch_nxt; // R21
		end
	end

	// per-link resets from control and reset words
	function automatic logic [1:0] link_rst_map(input logic [7:0] ctl, input logic [1:0] rs);
		return ctl[CTRL_TWO_LINK_BIT] ? rs : {rs[0], rs[0]};
	endfunction

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	lane_off_a: assert property ( // R14
		reg_wr_i && reg_addr_i == ADDR_LANE_PWR_OFF |=> lane_power_off_o == $past(reg_wdata_i))
		else $error("lane power-off mask not applied");
	sel_write_a: assert property ( // R12
		reg_wr_i && reg_addr_i == ADDR_CFG_FIRST && link_select
		|=> cfg_r[1][0] == $past(reg_wdata_i) && $stable(cfg_r[0][0]))
		else $error("link select did not steer write");
	mismatch_set_a: assert property ( // R21
		rx_cfg_sum_vld_i && rx_cfg_sum_i != held_sum_r[rx_cfg_link_i] |=> sum_mismatch_o)
		else $error("checksum mismatch not flagged");
	mismatch_hold_a: assert property ( // R21
		sum_mismatch_o && !clr_mismatch |=> sum_mismatch_o [*1])
		else $error("mismatch flag dropped without clear");
	hd_check_a: assert property ( // R5
		cfg_r[0][IDX_HD][HD_BIT] != (cfg_r[0][IDX_F] == 8'h00) |=> cfg_error_o)
		else $error("high density misuse not flagged");
	res_check_a: assert property ( // R6
		cfg_r[0][IDX_N][4:0] != RES_M1 |=> cfg_error_o)
		else $error("resolution not sixteen yet accepted");
	kcount_check_a: assert property ( // R7
		mode_r == 8'h04 && cfg_r[0][IDX_K][4:0] == K_SHORT_M1 |=> cfg_error_o)
		else $error("short multiframe accepted in mode 4");
	rate_check_a: assert property ( // R3
		lane_rate_mhz > LANE_RATE_MAX_MHZ |=> cfg_error_o)
		else $error("lane rate above window accepted");
	dual_mode_a: assert property ( // R9
		two_link_enable && mode_r < 8'h04 |=> cfg_error_o)
		else $error("dual link on single-only mode accepted");
	single_rst_a: assert property ( // R8
		!two_link_o |-> link_reset_o[1] == link_reset_o[0])
		else $error("single link resets diverge");
	descr_a: assert property ( // R11
		descramble_en_o == {cfg_r[1][IDX_L][SCR_BIT], cfg_r[0][IDX_L][SCR_BIT]})
		else $error("descrambler enable wrong");
	dual_cov_c: cover property (two_link_o && !cfg_error_o);
	mism_cov_c: cover property (rx_cfg_sum_vld_i ##1 sum_mismatch_o ##1 clr_mismatch);
	reg_sum_cov_c: cover property (checksum_method_sel && rx_cfg_sum_vld_i && !cfg_error_o);
endmodule

//--- rtl/jl_pkg.sv
// link parameter setup package: register map, field layout, mode table
// assumes byte-wide register access with 12-bit addresses
package jl_pkg;
	// ==========================================================
	// register addresses
	localparam logic [11:0] ADDR_LANE_PWR_OFF = 12'h201;
	localparam logic [11:0] ADDR_LINK_CTRL = 12'h300;
	localparam logic [11:0] ADDR_CFG_FIRST = 12'h450;
	localparam logic [11:0] ADDR_CFG_LAST = 12'h45a;
	localparam logic [11:0] ADDR_CFG_SUM = 12'h45d;
	localparam logic [11:0] ADDR_DAC_RATE_LO = 12'h0f0;
	localparam logic [11:0] ADDR_DAC_RATE_HI = 12'h0f1;
	localparam logic [11:0] ADDR_MODE = 12'h0f2;
	localparam logic [11:0] ADDR_UPSAMPLE = 12'h0f3;
	localparam logic [11:0] ADDR_STATUS = 12'h0f4;
	localparam logic [11:0] ADDR_LINK_RST = 12'h0f5;
	// ==========================================================
	// link control bits
	localparam int CTRL_SUM_METHOD_BIT = 6;
	localparam int CTRL_TWO_LINK_BIT = 3;
	localparam int CTRL_LINK_SEL_BIT = 2;
	// status bits
	localparam int ST_CFG_ERR_BIT = 0;
	localparam int ST_MISMATCH_BIT = 1;
	// ==========================================================
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_DAC_RATE = 16'h0000;
	// ==========================================================
	// configuration byte layout
	localparam int CFG_BYTES = 11;
	localparam int IDX_DID = 0;
	localparam int IDX_BID = 1;
	localparam int IDX_LID = 2;
	localparam int IDX_L = 3;
	localparam int IDX_F = 4;
	localparam int IDX_K = 5;
	localparam int IDX_M = 6;
	localparam int IDX_N = 7;
	localparam int IDX_NP = 8;
	localparam int IDX_S = 9;
	localparam int IDX_HD = 10;
	localparam int SCR_BIT = 7;
	localparam int HD_BIT = 7;
	localparam int PHADJ_BIT = 5;
	localparam int ADJDIR_BIT = 6;
	localparam int SUBCLASS_LSB = 5;
	// ==========================================================
	// numeric limits, all minus-one encoded where they meet fields
	localparam logic [4:0] RES_M1 = 5'd15;
	localparam logic [4:0] K_LONG_M1 = 5'd31;
	localparam logic [4:0] K_SHORT_M1 = 5'd15;
	localparam logic [31:0] LANE_RATE_MULT = 32'd20;
	localparam logic [31:0] LANE_RATE_MIN_MHZ = 32'd1440;
	localparam logic [31:0] LANE_RATE_MAX_MHZ = 32'd12400;
	// upsample mode codes
	localparam logic [7:0] UPS_1X = 8'h00;
	localparam logic [7:0] UPS_2X = 8'h01;
	localparam logic [7:0] UPS_4X = 8'h03;
	localparam logic [7:0] UPS_8X = 8'h04;
	// ==========================================================
	// operating mode table
	typedef struct packed {
		logic valid;
		logic dual_ok;
		logic k32_only;
		logic [3:0] m;
		logic [3:0] l;
		logic [3:0] s;
		logic [3:0] f;
	} jl_mode_s;

	function automatic jl_mode_s jl_mode_info(input logic [7:0] mode);
		jl_mode_s i;
		i = '{valid: 1'b1, dual_ok: 1'b0, k32_only: 1'b0,
			m: 4'h4, l: 4'h8, s: 4'h1, f: 4'h1};
		case (mode)
			8'h00: i.k32_only = 1'b1;
			8'h01: begin i.s = 4'h2; i.f = 4'h2; end
			8'h02: begin i.l = 4'h4; i.f = 4'h2; end
			8'h03: begin i.l = 4'h2; i.f = 4'h4; end
			8'h04: begin i = '{1'b1, 1'b1, 1'b1, 4'h2, 4'h4, 4'h1, 4'h1}; end
			8'h05: begin i = '{1'b1, 1'b1, 1'b0, 4'h2, 4'h4, 4'h2, 4'h2}; end
			8'h06: begin i = '{1'b1, 1'b1, 1'b0, 4'h2, 4'h2, 4'h1, 4'h2}; end
			8'h07: begin i = '{1'b1, 1'b1, 1'b0, 4'h2, 4'h1, 4'h1, 4'h4}; end
			8'h09: begin i = '{1'b1, 1'b1, 1'b1, 4'h1, 4'h2, 4'h1, 4'h1}; end
			8'h0a: begin i = '{1'b1, 1'b1, 1'b0, 4'h1, 4'h1, 4'h1, 4'h2}; end
			default: begin i = '{1'b0, 1'b0, 1'b0, 4'h1, 4'h1, 4'h1, 4'h1}; end
		endcase
		return i;
	endfunction
endpackage
